// ### dsr_bank.sv
// Display settings register bank with backlight and page cycling control
//
// Contract
// RULE_01: Read-only 128-bit identification string sits at the display area start.
// RULE_02: Backlight mode 0 lights on button press, 1 always lit, 2 dark.
// RULE_03: In mode 0 backlight stays lit for backlight seconds after a press.
// RULE_04: Page mode 0 cycles pages, 1 lists them; reset value 0.
// RULE_05: Cycling mode with auto-advance steps pages without button input.
// RULE_06: Each page dwells for the dwell seconds, default 10, before advancing.
// RULE_07: A button press pauses auto-advance for resume seconds, default 90.
// RULE_08: Separator codes 0..8 pick thousands and decimal symbols in pairs.
// RULE_09: New separator code applies only on page re-entry or restart.
// RULE_10: Writing the key to the reboot register restarts the device.
// RULE_11: Multi-word values place the most significant word at lower address.
// RULE_12: Writes to the identification string are ignored.
`default_nettype none

`include "dsr_regs.svh"

module dsr_bank
  import dsr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `DSR_SECOND_CYCLES,
  parameter logic [127:0] IDENT     = 128'h4453_504c_5f4c_4f47_5f4d_4f44_5f30_3031
)
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Protocol register access
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  output logic             reg_rvalid_out,
  // Front panel events
  input  wire logic        button_press_in,
  input  wire logic        page_enter_in,
  // Display control
  output logic             backlight_out,
  output logic             page_advance_out,
  output logic             list_mode_out,
  output logic      [15:0] contrast_out,
  output logic      [2:0]  thousands_sep_out,
  output logic             decimal_comma_out,
  output logic             reboot_out
);

  // IDENT value is arbitrary

  // ****************************************************************
  // State
  // ****************************************************************
  dsr_bank_s st;
  dsr_bank_s next_st;

  logic bl_busy;
  logic dwell_busy;
  logic dwell_expire;
  logic resume_busy;
  logic resume_expire;
  logic cycling;
  logic wr_hit_reboot;
  logic [3:0] sep_now;

  // ****************************************************************
  // Second timers
  // ****************************************************************
  // Auto-advance only counts while in cycling mode with auto-advance on
  assign cycling = (st.page_mode == 16'h0000) && (st.auto_adv == 16'h0001); // see RULE_05

  dsr_sec_timer u_bl_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (button_press_in),  // see RULE_03
    .stop_in    (1'b0),
    .secs_in    (st.bl_secs),
    .tick_in    (st.tick),
    .busy_out   (bl_busy),
    .expire_out ()
  );

  // Reloaded after each step, after a pause ends, and when cycling is enabled
  dsr_sec_timer u_dwell_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (cycling && !resume_busy && (dwell_expire || resume_expire ||
                 !dwell_busy)), // see RULE_06
    .stop_in    (!cycling || resume_busy),
    .secs_in    (st.dwell_secs),
    .tick_in    (st.tick),
    .busy_out   (dwell_busy),
    .expire_out (dwell_expire)
  );

  dsr_sec_timer u_resume_timer (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (button_press_in && cycling), // see RULE_07
    .stop_in    (!cycling),
    .secs_in    (st.resume_secs),
    .tick_in    (st.tick),
    .busy_out   (resume_busy),
    .expire_out (resume_expire)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign wr_hit_reboot = reg_wr_in && (reg_addr_in == `DSR_OFS_REBOOT) &&
                         (reg_wdata_in == `DSR_REBOOT_KEY); // see RULE_10
  assign sep_now       = (st.separator > `DSR_SEP_MAX) ? 4'h0 : st.separator[3:0];

  always_comb begin
    next_st = st;
    next_st.rvalid  = 1'b0;
    next_st.reboot  = 1'b0;
    next_st.advance = 1'b0;

    // One-second tick; counter is a parameter so benches can shorten it
    if (st.prescale >= SEC_CYCLES - 1) begin
      next_st.prescale = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 32'h0000_0001;
      next_st.tick     = 1'b0;
    end

    // Register writes; identification words and unmapped offsets fall through
    if (reg_wr_in) begin
      if (reg_addr_in == `DSR_OFS_BL_MODE) begin
        next_st.bl_mode = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_BL_SECS) begin
        next_st.bl_secs = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_PAGE_MODE) begin
        next_st.page_mode = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_AUTO_ADV) begin
        next_st.auto_adv = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_DWELL_SECS) begin
        next_st.dwell_secs = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_RESUME_SECS) begin
        next_st.resume_secs = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_CONTRAST) begin
        next_st.contrast = reg_wdata_in;
      end else if (reg_addr_in == `DSR_OFS_SEPARATOR) begin
        next_st.separator = reg_wdata_in;
      end
    end // Identification string stays untouched, see RULE_12

    // Reads answer one cycle later; unmapped offsets read zero
    if (reg_rd_in) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 16'h0000;
      if ((reg_addr_in >= `DSR_OFS_IDENT) &&
          (reg_addr_in < `DSR_OFS_IDENT + 16'(`DSR_IDENT_WORDS))) begin
        // Most significant word first, see RULE_01 and RULE_11
        next_st.rdata = IDENT[127 - 16 * (reg_addr_in[2:0]) -: 16];
      end else if (reg_addr_in == `DSR_OFS_BL_MODE) begin
        next_st.rdata = st.bl_mode;
      end else if (reg_addr_in == `DSR_OFS_BL_SECS) begin
        next_st.rdata = st.bl_secs;
      end else if (reg_addr_in == `DSR_OFS_PAGE_MODE) begin
        next_st.rdata = st.page_mode;
      end else if (reg_addr_in == `DSR_OFS_AUTO_ADV) begin
        next_st.rdata = st.auto_adv;
      end else if (reg_addr_in == `DSR_OFS_DWELL_SECS) begin
        next_st.rdata = st.dwell_secs;
      end else if (reg_addr_in == `DSR_OFS_RESUME_SECS) begin
        next_st.rdata = st.resume_secs;
      end else if (reg_addr_in == `DSR_OFS_CONTRAST) begin
        next_st.rdata = st.contrast;
      end else if (reg_addr_in == `DSR_OFS_SEPARATOR) begin
        next_st.rdata = st.separator;
      end
    end

    // Separator style is latched on page entry and cleared on restart, see RULE_09
    if (page_enter_in) begin
      next_st.sep_applied = sep_now;
    end

    // Decode of the applied style, see RULE_08
    case (st.sep_applied)
      4'h0, 4'h1: next_st.thou_sep = DSR_TH_NONE;
      4'h2, 4'h3: next_st.thou_sep = DSR_TH_SPACE;
      4'h4, 4'h5: next_st.thou_sep = DSR_TH_COMMA;
      4'h6, 4'h7: next_st.thou_sep = DSR_TH_PERIOD;
      default:    next_st.thou_sep = DSR_TH_APOSTROPHE;
    endcase
    next_st.dec_comma = st.sep_applied[0] && (st.sep_applied != 4'h8); // see RULE_08

    // Backlight behaviour, see RULE_02
    case (st.bl_mode[1:0])
      2'(DSR_BL_BUTTON): next_st.backlight = bl_busy; // see RULE_03
      2'(DSR_BL_ALWAYS): next_st.backlight = 1'b1;
      default:           next_st.backlight = 1'b0;
    endcase

    next_st.advance   = dwell_expire && cycling && !resume_busy; // see RULE_05
    next_st.list_mode = (st.page_mode == 16'h0001);             // see RULE_04

    // Restart returns every setting to its reset value, see RULE_10
    if (wr_hit_reboot) begin
      next_st             = '0;
      next_st.bl_mode     = `DSR_RST_BL_MODE;
      next_st.bl_secs     = `DSR_RST_BL_SECS;
      next_st.page_mode   = `DSR_RST_PAGE_MODE;
      next_st.auto_adv    = `DSR_RST_AUTO_ADV;
      next_st.dwell_secs  = `DSR_RST_DWELL_SECS;
      next_st.resume_secs = `DSR_RST_RESUME_SECS;
      next_st.contrast    = `DSR_RST_CONTRAST;
      next_st.separator   = `DSR_RST_SEPARATOR;
      next_st.reboot      = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st             <= '0;
      st.bl_mode     <= `DSR_RST_BL_MODE;
      st.bl_secs     <= `DSR_RST_BL_SECS;
      st.page_mode   <= `DSR_RST_PAGE_MODE;  // see RULE_04
      st.auto_adv    <= `DSR_RST_AUTO_ADV;
      st.dwell_secs  <= `DSR_RST_DWELL_SECS; // see RULE_06
      st.resume_secs <= `DSR_RST_RESUME_SECS; // see RULE_07
      st.contrast    <= `DSR_RST_CONTRAST;
      st.separator   <= `DSR_RST_SEPARATOR;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_out     = st.rdata;
  assign reg_rvalid_out    = st.rvalid;
  assign backlight_out     = st.backlight;
  assign page_advance_out  = st.advance;
  assign list_mode_out     = st.list_mode;
  assign contrast_out      = st.contrast;
  assign thousands_sep_out = st.thou_sep;
  assign decimal_comma_out = st.dec_comma;
  assign reboot_out        = st.reboot;

endmodule : dsr_bank

`default_nettype wire

// ### dsr_bank_props.sv
// Port checker for the display settings bank
`default_nettype none
`include "dsr_regs.svh"
module dsr_bank_props
  import dsr_pkg::*;
#(parameter logic [127:0] IDENT = '0)
(
  // Clock, reset and register port
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  // Panel events and display control
  input wire logic        button_press_in,
  input wire logic        page_enter_in,
  input wire logic        backlight_out,
  input wire logic        page_advance_out,
  input wire logic        list_mode_out,
  input wire logic [15:0] contrast_out,
  input wire logic [2:0]  thousands_sep_out,
  input wire logic        decimal_comma_out,
  input wire logic        reboot_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        key_wr;
  logic [15:0] bl_h;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****
  // Backlight mode shadow, cleared on reboot as the bank is
  // ****
  assign key_wr = reg_wr_in && reg_addr_in == `DSR_OFS_REBOOT && reg_wdata_in == `DSR_REBOOT_KEY;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || key_wr) begin
      bl_h <= 16'h0000;
    end else if (reg_wr_in && reg_addr_in == `DSR_OFS_BL_MODE) begin
      bl_h <= reg_wdata_in;
    end
  end
  sequence s_rd(logic [15:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_wr(logic [15:0] a, logic [15:0] d);
    reg_wr_in && reg_addr_in == a && reg_wdata_in == d;
  endsequence
  property p_rd_ans; reg_rd_in |=> reg_rvalid_out; endproperty
  property p_id_hi; s_rd(`DSR_OFS_IDENT) |=> reg_rdata_out == IDENT[127:112]; endproperty
  property p_key;
    s_wr(`DSR_OFS_REBOOT, `DSR_REBOOT_KEY) |=> reboot_out ##1 contrast_out == 16'h0004;
  endproperty
  property p_no_key; reg_wr_in && reg_addr_in == `DSR_OFS_REBOOT && !key_wr |=> !reboot_out;
  endproperty
  property p_list; s_wr(`DSR_OFS_PAGE_MODE, 16'h0001) |=> ##1 list_mode_out; endproperty
  property p_bl_on;
    bl_h == 16'h0001 && $past(bl_h) == 16'h0001 && $past(bl_h, 2) == 16'h0001 |-> backlight_out;
  endproperty
  property p_bl_off;
    bl_h == 16'h0002 && $past(bl_h) == 16'h0002 && $past(bl_h, 2) == 16'h0002 |-> !backlight_out;
  endproperty
  property p_no_adv; list_mode_out && $past(list_mode_out) |-> !page_advance_out; endproperty
  // Style outputs move only after a page entry or a restart
  property p_sep_hold;
    !$past(page_enter_in) && !$past(page_enter_in, 2) && !$past(reboot_out) &&
      !$past(reboot_out, 2) && $past(rst_n_in, 3) |-> $stable(thousands_sep_out) &&
      $stable(decimal_comma_out);
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_id_hi: assert property (p_id_hi)
    else $error("ident high word wrong");
  a_key: assert property (p_key)
    else $error("key write did not restart");
  a_no_key: assert property (p_no_key)
    else $error("restart without key");
  a_list: assert property (p_list)
    else $error("list mode not shown");
  a_bl_on: assert property (p_bl_on)
    else $error("backlight not lit");
  a_bl_off: assert property (p_bl_off)
    else $error("backlight not dark");
  a_no_adv: assert property (p_no_adv)
    else $error("page step in list mode");
  a_sep_hold: assert property (p_sep_hold)
    else $error("style changed early");
endmodule : dsr_bank_props
bind dsr_bank dsr_bank_props #(.IDENT(IDENT)) i_dsr_bank_props (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .button_press_in(button_press_in), .page_enter_in(page_enter_in),
  .backlight_out(backlight_out), .page_advance_out(page_advance_out),
  .list_mode_out(list_mode_out), .contrast_out(contrast_out),
  .thousands_sep_out(thousands_sep_out), .decimal_comma_out(decimal_comma_out),
  .reboot_out(reboot_out)
);
`default_nettype wire

// ### dsr_bank_tb.sv
// Self-checking bench of the display settings bank
`default_nettype none
`include "dsr_regs.svh"
module dsr_bank_tb
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [127:0] ID_VAL = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978; // Arbitrary
  localparam int SEC = 20;
  logic        sys_clk = 1'b0;
  logic        rst_n, button, page_enter, wr, rd, rvalid, light, adv, list, dec, boot;
  logic [15:0] addr, wdata, rdata, contrast;
  logic [2:0]  thou;
  int          failures = 0;
  int          checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  dsr_bank #(.SEC_CYCLES(SEC), .IDENT(ID_VAL)) i_dsr_bank (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .button_press_in(button), .page_enter_in(page_enter), .backlight_out(light),
    .page_advance_out(adv), .list_mode_out(list), .contrast_out(contrast),
    .thousands_sep_out(thou), .decimal_comma_out(dec), .reboot_out(boot));
  dsr_master i_dsr_master (
    .sys_clk_in(sys_clk), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));
  // ****
  // Shared helpers
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask : pulse
  // Cycles to the next page step; lim + 1 means none came
  task automatic wait_adv(input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge sys_clk);
      #1;
      if (adv === 1'b1) return;
    end
  endtask : wait_adv
  task automatic chk_defaults;
    logic [15:0] d;
    logic [15:0] ofs [8] = '{`DSR_OFS_BL_MODE, `DSR_OFS_BL_SECS, `DSR_OFS_PAGE_MODE,
      `DSR_OFS_AUTO_ADV, `DSR_OFS_DWELL_SECS, `DSR_OFS_RESUME_SECS, `DSR_OFS_CONTRAST,
      `DSR_OFS_SEPARATOR};
    logic [15:0] rv [8] = '{16'h0000, 16'h005a, 16'h0000, 16'h0001, 16'h000a, 16'h005a,
      16'h0004, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      i_dsr_master.rd(ofs[i], d);
      check("reset value", d, rv[i]);
    end
    check("contrast out", contrast, 16'h0004);
  endtask : chk_defaults
  // ****
  // Scenarios
  // ****
  task automatic t_ident;
    logic [15:0] d;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        i_dsr_master.rd(`DSR_OFS_IDENT + 16'(i), d);
        check("ident word", d, ID_VAL[127 - 16 * i -: 16]);
        i_dsr_master.wr(`DSR_OFS_IDENT + 16'(i), ~d);
      end
    end
    i_dsr_master.wr(16'h4010, 16'h1234);
    i_dsr_master.rd(16'h4010, d);
    check("unmapped", d, 16'h0000);
    $display("ident done");
  endtask : t_ident
  // Dwell span, pause after a press, then auto stepping off
  task automatic t_cycle;
    int n;
    i_dsr_master.wr(`DSR_OFS_DWELL_SECS, 16'h0003);
    i_dsr_master.wr(`DSR_OFS_RESUME_SECS, 16'h0002);
    wait_adv(300, n);
    wait_adv(300, n);
    check("dwell span", 16'(n), 16'(3 * SEC));
    pulse(button);
    wait_adv(300, n);
    check("resume span", 16'(n >= 70 && n <= 110), 16'h0001);
    i_dsr_master.wr(`DSR_OFS_AUTO_ADV, 16'h0000);
    wait_adv(300, n);
    check("auto off", 16'(n), 16'(301));
    i_dsr_master.wr(`DSR_OFS_AUTO_ADV, 16'h0001);
    $display("cycle done");
  endtask : t_cycle
  task automatic t_list;
    int n;
    i_dsr_master.wr(`DSR_OFS_PAGE_MODE, 16'h0001);
    wait_adv(300, n);
    check("list out", list, 16'h0001);
    check("no step in list", 16'(n), 16'(301));
    i_dsr_master.wr(`DSR_OFS_PAGE_MODE, 16'h0000);
    wait_adv(300, n);
    check("cycling again", 16'(n <= 90), 16'h0001);
    $display("list done");
  endtask : t_list
  task automatic t_light;
    int n;
    // An earlier press may still hold the light; let it run out first
    for (n = 0; n < 2000 && light === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check("dark before press", light, 16'h0000);
    i_dsr_master.wr(`DSR_OFS_BL_SECS, 16'h0002);
    pulse(button);
    repeat (3) @(posedge sys_clk);
    #1;
    check("lit after press", light, 16'h0001);
    for (n = 0; n < 200 && light === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check("lit time", 16'(n >= 15 && n <= 65), 16'h0001);
    for (int m = 1; m < 3; m++) begin
      i_dsr_master.wr(`DSR_OFS_BL_MODE, 16'(m));
      repeat (4) @(posedge sys_clk);
      #1;
      check("mode level", light, 16'(m == 1));
    end
    i_dsr_master.wr(`DSR_OFS_BL_MODE, 16'h0000);
    $display("light done");
  endtask : t_light
  // Codes 0 to 9; 9 is out of range and shows as code 0
  task automatic t_sep;
    logic [2:0] th;
    logic       dc;
    for (int c = 0; c < 10; c++) begin
      th = thou;
      i_dsr_master.wr(`DSR_OFS_SEPARATOR, 16'(c));
      repeat (3) @(posedge sys_clk);
      #1;
      check("style held", thou, th);
      pulse(page_enter);
      repeat (3) @(posedge sys_clk);
      #1;
      check("thousands", thou, 16'((c > 8) ? 0 : c / 2));
      if (c % 2 == 1 && c < 8) check("decimal", dec, 16'(!dc));
      dc = dec;
    end
    $display("sep done");
  endtask : t_sep
  task automatic t_reboot;
    i_dsr_master.wr(`DSR_OFS_CONTRAST, 16'h0007);
    i_dsr_master.wr(`DSR_OFS_REBOOT, 16'h1234);
    check("wrong key kept", contrast, 16'h0007);
    i_dsr_master.wr(`DSR_OFS_REBOOT, `DSR_REBOOT_KEY);
    check("reboot pulse", boot, 16'h0001);
    chk_defaults;
    $display("reboot done");
  endtask : t_reboot
  // Main sequence after ten reset cycles
  initial begin
    rst_n      = 1'b0;
    button     = 1'b0;
    page_enter = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    chk_defaults;
    t_ident;
    t_cycle;
    t_list;
    t_light;
    t_sep;
    t_reboot;
    stop_test;
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #(20000 * 25);
    failures++;
    stop_test;
  end
endmodule : dsr_bank_tb
`default_nettype wire

// ### dsr_master.sv
// Protocol master model driving the bank's register port
`default_nettype none
module dsr_master
  import dsr_pkg::*;
(
  // Clock and read answer
  input  wire logic        sys_clk_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  // Request
  output logic      [15:0] reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic      [15:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr_out  = 16'h0000;
    reg_wdata_out = 16'h0000;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end
  // ****
  // Word transfers; released lines are inverted so stale values never pass
  // ****
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr
  // Wide values are fetched by the caller lower address first
  // The answer stands for one cycle only, so it is taken mid-cycle while valid is up
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 16'hxxxx;
  endtask : rd
endmodule : dsr_master
`default_nettype wire

// ### dsr_pkg.sv
// Types shared by the display settings bank and its second timers
`default_nettype none

package dsr_pkg;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    DSR_BL_BUTTON,
    DSR_BL_ALWAYS,
    DSR_BL_OFF
  } dsr_bl_mode_e;

  // Thousands separator styles
  typedef enum logic [2:0] {
    DSR_TH_NONE,
    DSR_TH_SPACE,
    DSR_TH_COMMA,
    DSR_TH_PERIOD,
    DSR_TH_APOSTROPHE
  } dsr_thou_e;

  typedef logic [15:0] dsr_word_t;

  // ****************************************************************
  // State records
  // ****************************************************************
  typedef struct packed {
    logic [15:0] secs_left;
    logic        busy;
    logic        expire;
  } dsr_timer_s;

  typedef struct packed {
    dsr_word_t bl_mode;
    dsr_word_t bl_secs;
    dsr_word_t page_mode;
    dsr_word_t auto_adv;
    dsr_word_t dwell_secs;
    dsr_word_t resume_secs;
    dsr_word_t contrast;
    dsr_word_t separator;
    logic [3:0] sep_applied;
    logic [31:0] prescale;
    logic        tick;
    dsr_word_t rdata;
    logic        rvalid;
    logic        reboot;
    logic        backlight;
    logic        advance;
    logic        list_mode;
    dsr_thou_e   thou_sep;
    logic        dec_comma;
  } dsr_bank_s;

endpackage : dsr_pkg

`default_nettype wire

// ### dsr_regs.svh
// Offsets, reset values, keys and timing figures of the display settings bank
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// ****************************************************************
// Protocol register offsets (one 16-bit protocol register each)
// ****************************************************************
`define DSR_OFS_IDENT        16'h4000
`define DSR_IDENT_WORDS      8
`define DSR_OFS_BL_MODE      16'h4016
`define DSR_OFS_BL_SECS      16'h4017
`define DSR_OFS_PAGE_MODE    16'h401a
`define DSR_OFS_AUTO_ADV     16'h401b
`define DSR_OFS_DWELL_SECS   16'h401c
`define DSR_OFS_RESUME_SECS  16'h401d
`define DSR_OFS_CONTRAST     16'h401e
`define DSR_OFS_SEPARATOR    16'h401f
`define DSR_OFS_REBOOT       16'h0609

// ****************************************************************
// Reset values and keys
// ****************************************************************
`define DSR_RST_BL_MODE      16'h0000
`define DSR_RST_BL_SECS      16'h005a
`define DSR_RST_PAGE_MODE    16'h0000
`define DSR_RST_AUTO_ADV     16'h0001
`define DSR_RST_DWELL_SECS   16'h000a
`define DSR_RST_RESUME_SECS  16'h005a
`define DSR_RST_CONTRAST     16'h0004
`define DSR_RST_SEPARATOR    16'h0000
`define DSR_REBOOT_KEY       16'haa55
`define DSR_SEP_MAX          16'h0008

// ****************************************************************
// Timing
// ****************************************************************
`define DSR_CLK_HZ           40000000
`define DSR_SECOND_S         1
`define DSR_SECOND_CYCLES    (`DSR_CLK_HZ * `DSR_SECOND_S)

`endif

// ### dsr_sec_timer.sv
// Down counter of whole seconds with a busy level and an expiry pulse
`default_nettype none

module dsr_sec_timer
  import dsr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Control
  input  wire logic        load_in,
  input  wire logic        stop_in,
  input  wire logic [15:0] secs_in,
  input  wire logic        tick_in,
  // Status
  output logic             busy_out,
  output logic             expire_out
);

  dsr_timer_s st;
  dsr_timer_s next_st;

  // Load wins over stop and over counting
  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (load_in) begin
      next_st.secs_left = secs_in;
      next_st.busy      = 1'b1;
    end else if (stop_in) begin
      next_st.busy = 1'b0;
    end else if (st.busy && tick_in) begin
      if (st.secs_left <= 16'h0001) begin
        next_st.secs_left = 16'h0000;
        next_st.busy      = 1'b0;
        next_st.expire    = 1'b1;
      end else begin
        next_st.secs_left = st.secs_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out   = st.busy;
  assign expire_out = st.expire;

endmodule : dsr_sec_timer

`default_nettype wire
